// File: dv/tcm_board.sv
/*
   board model: free low-frequency clock, pulled-up event source, port latches on the pins.
   assumes pclk from the bench; pulse tasks called by the bench.
*/
module tcm_board #(
   parameter FS_HALF = 10
) (
   input  wire logic       pclk,
   output logic            low_freq_clock,
   output logic [1:0]      event_input_pin,
   input  wire logic [1:0] divider_out_pin,
   input  wire logic [1:0] pwm_out_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] port_latch;
   wire  [1:0] board_level;
   wire  [1:0] pwm_level;
   assign board_level = port_latch & divider_out_pin;
   assign pwm_level = port_latch & pwm_out_pin;
   initial begin
      port_latch = 2'b11;
      low_freq_clock = 1'b0;
      event_input_pin = 2'b11;
      forever begin
         repeat (FS_HALF) @(posedge pclk);
         low_freq_clock <= ~low_freq_clock;
      end
   end
   // shorter levels would be missed by the synchroniser
   task automatic ev_pulse(input int ch, input int lo, input int hi);
      @(posedge pclk);
      event_input_pin[ch] <= 1'b0;
      repeat ((lo < 2) ? 2 : lo) @(posedge pclk);
      event_input_pin[ch] <= 1'b1;
      repeat ((hi < 2) ? 2 : hi) @(posedge pclk);
   endtask
endmodule

// File: dv/tcm_top_assertions.sv
/*
   checker for the dual timer: apb answer, pin polarity, reset, stopped channel_a, match pulse.
   assumes binding into tcm_top, pclk the only clock.
*/
module tcm_top_chk #(
   parameter NUM_CH = 2
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [7:0]        paddr,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              low_freq_clock,
   input wire logic [NUM_CH-1:0] event_input_pin,
   input wire logic [NUM_CH-1:0] divider_out_pin,
   input wire logic [NUM_CH-1:0] pwm_out_pin,
   input wire logic [NUM_CH-1:0] channel_match_irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic run_a;
   logic wr_a;
   logic rd_cnt;
   // run bit of channel_a as software last wrote it
   assign wr_a = psel && penable && pready && pwrite && (paddr == 8'h00);
   assign rd_cnt = psel && penable && !pwrite && (paddr == 8'h0c);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_a <= 1'b0;
      end else if (wr_a) begin
         run_a <= pwdata[3];
      end
   end
   property p_pins_same;
      divider_out_pin == pwm_out_pin;
   endproperty
   a_pins_same: assert property (p_pins_same) else $error("pin outputs differ");
   property p_release;
      $rose(presetn) |-> (&divider_out_pin) && !(|channel_match_irq);
   endproperty
   a_release: assert property (p_release) else $error("pins not idle after reset");
   property p_irq_short;
      channel_match_irq[0] |=> !channel_match_irq[0] [*6];
   endproperty
   a_irq_short: assert property (p_irq_short) else $error("match pulse too long");
   property p_err;
      psel && penable && (paddr[1:0] == 2'b00) |-> pslverr == (paddr > 8'h20);
   endproperty
   a_err: assert property (p_err) else $error("error response wrong");
   property p_err_zero;
      psel && penable && !pwrite && pslverr |-> prdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("unmapped read not zero");
   // three stopped cycles cover a stop write landing on a tick edge
   property p_stop_count;
      rd_cnt && !run_a && !$past(run_a) && !$past(run_a, 2) |-> prdata == 32'h0;
   endproperty
   a_stop_count: assert property (p_stop_count) else $error("stopped count not zero");
   property p_stop_irq;
      !run_a && !$past(run_a) && !$past(run_a, 2) |-> !channel_match_irq[0];
   endproperty
   a_stop_irq: assert property (p_stop_irq) else $error("match while stopped");
   property p_stop_hold;
      !run_a && !$past(run_a) && !$past(wr_a) |-> $stable(divider_out_pin[0]);
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stopped pin moved");
   c_irq_a: cover property (channel_match_irq[0]);
   c_irq_b: cover property (channel_match_irq[1]);
   c_err: cover property (psel && penable && pslverr);
endmodule

bind tcm_top tcm_top_chk #(.NUM_CH(NUM_CH)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .low_freq_clock(low_freq_clock), .event_input_pin(event_input_pin),
   .divider_out_pin(divider_out_pin), .pwm_out_pin(pwm_out_pin), .channel_match_irq(channel_match_irq));

// File: dv/test_eight_bit_timer_counter_modes.sv
/*
   self-checking bench for the dual timer: apb master, read monitor, timing probes.
   assumes tcm_top, its checker and tcm_board are compiled first.
*/
module test_eight_bit_timer_counter_modes;
   timeunit 1ns;
   timeprecision 1ps;
   localparam FS_HALF = 10;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   wire  [31:0] prdata;
   wire         pready;
   wire         pslverr;
   wire         low_freq_clock;
   wire  [1:0]  event_input_pin;
   wire  [1:0]  divider_out_pin;
   wire  [1:0]  pwm_out_pin;
   wire  [1:0]  channel_match_irq;
   logic [31:0] exp_q[$];
   logic [7:0]  rst_addr[6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h20};
   int          n_mismatch;
   int          check_count;
   int          cyc;
   int          t0;
   int          t1;
   int          v;
   int          d1;
   int          d2;
   logic        lvl;
   tcm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .low_freq_clock(low_freq_clock), .event_input_pin(event_input_pin), .divider_out_pin(divider_out_pin),
      .pwm_out_pin(pwm_out_pin), .channel_match_irq(channel_match_irq));
   tcm_board #(.FS_HALF(FS_HALF)) board (.pclk(pclk), .low_freq_clock(low_freq_clock),
      .event_input_pin(event_input_pin), .divider_out_pin(divider_out_pin), .pwm_out_pin(pwm_out_pin));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
         chk(prdata, exp_q.pop_front(), "prdata");
      end
   end
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      if (!wr) exp_q.push_back(e);
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) n_mismatch++;
      chk(pslverr, a > 8'h20, "pslverr");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, e);
   endtask
   // flags are registered, so the pre-update value at an edge is settled
   task automatic wait_irq(input int ch, output int t);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (channel_match_irq[ch] !== 1'b1 && n < 3000);
      if (n >= 3000) n_mismatch++;
      t = cyc;
   endtask
   task automatic wait_chg(input int ch, output int t);
      int n;
      logic p;
      p = divider_out_pin[ch];
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (divider_out_pin[ch] === p && n < 3000);
      if (n >= 3000) n_mismatch++;
      t = cyc;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      {n_mismatch, check_count, cyc} = '0;
      void'($urandom(32'h99f8));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rst_addr[i]) rd(rst_addr[i], 32'h0);
      rd(8'h24, 32'h0);
      wr(8'h28, 32'h5);
      chk(divider_out_pin, 2'b11, "reset pins");
      for (int s = 1; s <= 3; s++) begin
         v = 1 + $urandom % 3;
         wr(8'h04, v);
         wr(8'h00, {24'h0, 1'b0, s[2:0], 4'h0});
         wr(8'h00, {24'h0, 1'b0, s[2:0], 4'h8});
         wait_irq(0, t0);
         wait_irq(0, t1);
         chk(t1 - t0, v << (9 - 2 * s), "timer period");
         wr(8'h00, {24'h0, 1'b0, s[2:0], 4'h0});
         rd(8'h0c, 32'h0);
      end
      wr(8'h20, 32'h1);
      wr(8'h04, 32'h1);
      wr(8'h00, 32'h08);
      wait_irq(0, t0);
      wait_irq(0, t1);
      chk(t1 - t0, 16 * FS_HALF, "slow tap period");
      wr(8'h00, 32'h00);
      wr(8'h20, 32'h0);
      v = 2 + $urandom % 5;
      wr(8'h14, v);
      wr(8'h10, 32'h39);
      wait_chg(1, t0);
      chk(divider_out_pin[1], 1'b0, "first toggle");
      wait_chg(1, t1);
      chk(t1 - t0, v * 8, "divider half period");
      wr(8'h10, 32'h31);
      @(posedge pclk);
      lvl = board.board_level[1];
      repeat (40) @(posedge pclk);
      chk(board.board_level[1], lvl, "held pin");
      wr(8'h10, 32'h30);
      @(posedge pclk);
      chk(divider_out_pin[1], 1'b1, "cleared flop");
      wr(8'h10, 32'hb0);
      @(posedge pclk);
      chk(pwm_out_pin[1], 1'b0, "preset flop");
      wr(8'h10, 32'h30);
      wr(8'h14, 32'h3);
      wr(8'h10, 32'h78);
      board.ev_pulse(1, 2, 2);
      board.ev_pulse(1, 7, 5);
      repeat (4) @(posedge pclk);
      rd(8'h1c, 32'h2);
      fork
         board.ev_pulse(1, 3, 3);
         wait_irq(1, t0);
      join
      rd(8'h1c, 32'h0);
      wr(8'h10, 32'h30);
      d1 = 40 + $urandom % 200;
      d2 = 40 + $urandom % 200;
      wr(8'h00, 32'h62);
      wr(8'h08, d1);
      rd(8'h08, d1);
      wr(8'h00, 32'h6a);
      wait_irq(0, t0);
      wr(8'h08, d2);
      rd(8'h08, d1);
      wait_chg(0, t1);
      wait_irq(0, v);
      chk(v - t1, 256 - d1, "pwm low time");
      chk(v - t0, 256, "pwm period");
      rd(8'h08, d2);
      wr(8'h00, 32'h62);
      end_sim();
   end
endmodule

// File: logic/tcm_channel.v
/*
   one 8-bit timer/counter channel: up-counter, compare, double-buffered
   pwm duty value, output flip-flop and match pulse.
   assumes a one-cycle count tick on pclk from the owning block and
   register write strobes that coincide with the apb access edge.
*/
`include "tcm_defs.vh"

module tcm_channel #(
   parameter CNT_W = 8
) (
   input  wire             pclk,
   input  wire             presetn,
   input  wire             tick,
   input  wire             run,
   input  wire [2:0]       mode,
   input  wire             ctrl_wr,
   input  wire             wr_flop_level,
   input  wire [CNT_W-1:0] compare_value,
   input  wire             duty_wr,
   input  wire [CNT_W-1:0] duty_wdata,
   output reg  [CNT_W-1:0] count,
   output reg  [CNT_W-1:0] pwm_duty_value,
   output reg              out_flop,
   output reg              channel_match_irq
);

   localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   reg  [CNT_W-1:0] duty_hold;
   wire [CNT_W-1:0] next_count = count + CNT_ONE;
   wire             is_pwm     = (mode == `TCM_MODE_PWM);
   wire             is_cmp     = (mode == `TCM_MODE_TIMER) | (mode == `TCM_MODE_DIVIDER);
   wire             cmp_hit    = run & tick & is_cmp & (next_count == compare_value);
   wire             overflow   = run & tick & is_pwm & (&count);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count             <= {CNT_W{1'b0}};
         out_flop          <= 1'b0;
         channel_match_irq <= 1'b0;
         duty_hold         <= {CNT_W{1'b0}};
         pwm_duty_value    <= {CNT_W{1'b0}};
      end else begin
         channel_match_irq <= cmp_hit | overflow;
         if (!run) begin
            count <= {CNT_W{1'b0}};
         end else if (cmp_hit) begin
            count <= {CNT_W{1'b0}};
         end else if (overflow) begin
            count <= {CNT_W{1'b0}};
         end else if (tick & (is_cmp | is_pwm)) begin
            count <= next_count;
         end
         // preset only from a stopped state; a stop write leaves the level held
         if (ctrl_wr & !run) begin
            out_flop <= wr_flop_level;
         end else if (cmp_hit & (mode == `TCM_MODE_DIVIDER)) begin
            out_flop <= ~out_flop;
         end else if (overflow) begin
            out_flop <= ~out_flop;
         end else if (run & tick & is_pwm & (next_count == pwm_duty_value)) begin
            out_flop <= ~out_flop;
         end
         if (duty_wr) begin
            duty_hold <= duty_wdata;
         end
         // a write landing on the overflow edge is taken whole, not half-shifted
         if (duty_wr & (!run | overflow)) begin
            pwm_duty_value <= duty_wdata;
         end else if (overflow) begin
            pwm_duty_value <= duty_hold;
         end
      end
   end

endmodule

// File: logic/tcm_defs.vh
/*
   register map, control field positions, modes, clock selects and reset
   values for the dual 8-bit timer/counter.
   assumes inclusion by bare name from the timer design files.
*/
`ifndef TCM_DEFS_VH
`define TCM_DEFS_VH

// apb byte offsets, channel_a at base 0x00, channel_b at base 0x10
`define TCM_CH_STRIDE     8'h10
`define TCM_OFF_CTRL      4'h0
`define TCM_OFF_CMP       4'h4
`define TCM_OFF_DUTY      4'h8
`define TCM_OFF_COUNT     4'hc
`define TCM_ADDR_CONFIG   8'h20

// channel_control fields
`define TCM_CTRL_FLOP     7
`define TCM_CTRL_SEL_HI   6
`define TCM_CTRL_SEL_LO   4
`define TCM_CTRL_RUN      3
`define TCM_CTRL_MODE_HI  2
`define TCM_CTRL_MODE_LO  0

// config register fields
`define TCM_CFG_TAP       0
`define TCM_CFG_LOWSPEED  1

// operating modes
`define TCM_MODE_TIMER    3'h0
`define TCM_MODE_DIVIDER  3'h1
`define TCM_MODE_PWM      3'h2

// source clock selects
`define TCM_SEL_SLOWEST   3'h0
`define TCM_SEL_FC_DIV7   3'h1
`define TCM_SEL_FC_DIV5   3'h2
`define TCM_SEL_FC_DIV3   3'h3
`define TCM_SEL_FS        3'h4
`define TCM_SEL_FC_DIV1   3'h5
`define TCM_SEL_FC        3'h6
`define TCM_SEL_PIN       3'h7

// prescaler taps, as powers of two of the high-frequency clock, and the fs divider width
`define TCM_TAP_11        11
`define TCM_TAP_7         7
`define TCM_TAP_5         5
`define TCM_TAP_3         3
`define TCM_FS_DIV_W      3

// reset values
`define TCM_RST_CTRL      8'h00
`define TCM_RST_CMP       8'h00
`define TCM_RST_DUTY      8'h00
`define TCM_RST_CONFIG    2'h0

`endif

// File: logic/tcm_top.v
/*
   dual 8-bit timer/counter with apb register access: clock prescaler,
   source clock selection, pin synchronisers and two channel instances.
   assumes the high-frequency clock is pclk itself, the low-frequency
   clock arrives as a slow pin level, and i/o port latches sit outside.
*/
// Design decisions made here: the address map and the APB slave port.
`include "tcm_defs.vh"

module tcm_top #(
   parameter NUM_CH = 2,
   parameter CNT_W  = 8,
   parameter PRE_W  = 11
) (
   input  wire              pclk,
   input  wire              presetn,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [7:0]        paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output wire              pready,
   output wire              pslverr,
   input  wire              low_freq_clock,
   input  wire [NUM_CH-1:0] event_input_pin,
   output wire [NUM_CH-1:0] divider_out_pin,
   output wire [NUM_CH-1:0] pwm_out_pin,
   output wire [NUM_CH-1:0] channel_match_irq
);

   // prescaler on the high-frequency clock, which here is pclk itself
   reg  [PRE_W-1:0]          prescale;
   reg  [`TCM_FS_DIV_W-1:0]  fs_div;
   reg  [2:0]                fs_sync;
   reg  [1:0]                config_bits;
   wire                      fs_tick;
   wire                      fs8_tick;
   wire                      tap_fc11;
   wire                      tap_fc7;
   wire                      tap_fc5;
   wire                      tap_fc3;
   wire                      tap_fc1;
   wire                      prescaler_tap_select;
   wire                      low_speed_mode;
   wire                      setup_ph;
   wire                      wr_access;
   wire                      cfg_hit;
   wire [NUM_CH-1:0]         ch_hit;
   wire [31:0]               ch_rdata [0:NUM_CH-1];
   reg  [31:0]               next_prdata;
   integer                   ri;
   wire [3:0]                reg_off;
   wire [7:0]                reg_base;

   localparam [PRE_W-1:0]         PRE_ONE = {{(PRE_W-1){1'b0}}, 1'b1};
   localparam [`TCM_FS_DIV_W-1:0] FS_ONE  = {{(`TCM_FS_DIV_W-1){1'b0}}, 1'b1};

   assign prescaler_tap_select = config_bits[`TCM_CFG_TAP];
   assign low_speed_mode       = config_bits[`TCM_CFG_LOWSPEED];

   // each tap pulses once per period of its divided clock
   assign tap_fc11 = &prescale[`TCM_TAP_11-1:0];
   assign tap_fc7  = &prescale[`TCM_TAP_7-1:0];
   assign tap_fc5  = &prescale[`TCM_TAP_5-1:0];
   assign tap_fc3  = &prescale[`TCM_TAP_3-1:0];
   assign tap_fc1  = prescale[0];

   // low-frequency clock is sampled as a level; its rising edge is the tick
   assign fs_tick  = fs_sync[1] & ~fs_sync[2];
   assign fs8_tick = fs_tick & (&fs_div);

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale <= {PRE_W{1'b0}};
         fs_div   <= {`TCM_FS_DIV_W{1'b0}};
         fs_sync  <= 3'h0;
      end else begin
         prescale <= prescale + PRE_ONE;
         fs_sync  <= {fs_sync[1:0], low_freq_clock};
         if (fs_tick) begin
            fs_div <= fs_div + FS_ONE;
         end
      end
   end

   // apb slave: zero wait states, read data captured in the setup cycle
   assign pready    = 1'b1;
   assign setup_ph  = psel & ~penable;
   assign wr_access = psel & penable & pwrite;
   assign reg_off   = paddr[3:0];
   assign reg_base  = {paddr[7:4], 4'h0};
   assign cfg_hit   = (paddr == `TCM_ADDR_CONFIG);
   // unmapped addresses answer with an error and read as zero
   assign pslverr   = psel & penable & ~(cfg_hit | (|ch_hit));

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         config_bits <= `TCM_RST_CONFIG;
      end else if (wr_access & cfg_hit) begin
         config_bits <= pwdata[1:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_CH; gi = gi + 1) begin : gen_ch
         // window base worked out wide, then cut to the address width on purpose
         localparam integer BASE_I = gi * `TCM_CH_STRIDE;
         localparam [7:0]   BASE   = BASE_I[7:0];

         reg  [7:0]       channel_control;
         reg  [CNT_W-1:0] compare_value;
         reg  [2:0]       ev_sync;
         reg              tick;
         wire [CNT_W-1:0] count;
         wire [CNT_W-1:0] pwm_duty_value;
         wire             out_flop;
         wire             ev_fall;
         wire             in_range;
         wire             ctrl_wr;
         wire             cmp_wr;
         wire             duty_wr;
         wire             run;
         wire [2:0]       mode;
         wire [2:0]       sel;
         wire             is_pwm;
         reg  [31:0]      rd_word;

         assign run      = channel_control[`TCM_CTRL_RUN];
         assign mode     = channel_control[`TCM_CTRL_MODE_HI:`TCM_CTRL_MODE_LO];
         assign sel      = channel_control[`TCM_CTRL_SEL_HI:`TCM_CTRL_SEL_LO];
         assign is_pwm   = (mode == `TCM_MODE_PWM);
         assign in_range = (reg_base == BASE);
         assign ch_hit[gi] = in_range & ~reg_off[1] & ~reg_off[0];
         assign ctrl_wr  = wr_access & in_range & (reg_off == `TCM_OFF_CTRL);
         assign cmp_wr   = wr_access & in_range & (reg_off == `TCM_OFF_CMP);
         assign duty_wr  = wr_access & in_range & (reg_off == `TCM_OFF_DUTY);

         // event pin is asynchronous: two flops, then an edge detector on the second
         assign ev_fall  = ev_sync[2] & ~ev_sync[1];

         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               channel_control <= `TCM_RST_CTRL;
               compare_value   <= `TCM_RST_CMP;
               ev_sync         <= 3'h0;
            end else begin
               ev_sync <= {ev_sync[1:0], event_input_pin[gi]};
               if (ctrl_wr) begin
                  channel_control <= pwdata[7:0];
               end
               // no buffer stage: the comparison sees the new value next cycle
               if (cmp_wr) begin
                  compare_value <= pwdata[CNT_W-1:0];
               end
            end
         end

         // source clock selection; low-speed mode only keeps fs/8, fs for pwm and the event pin for timer
         always @* begin
            tick = 1'b0;
            case (sel)
               `TCM_SEL_SLOWEST: begin
                  if (prescaler_tap_select | low_speed_mode) begin
                     tick = fs8_tick;
                  end else begin
                     tick = tap_fc11;
                  end
               end
               `TCM_SEL_FC_DIV7: begin
                  tick = tap_fc7 & ~low_speed_mode;
               end
               `TCM_SEL_FC_DIV5: begin
                  tick = tap_fc5 & ~low_speed_mode;
               end
               `TCM_SEL_FC_DIV3: begin
                  tick = tap_fc3 & ~low_speed_mode;
               end
               `TCM_SEL_FS: begin
                  tick = fs_tick & is_pwm;
               end
               `TCM_SEL_FC_DIV1: begin
                  tick = tap_fc1 & is_pwm & ~low_speed_mode;
               end
               `TCM_SEL_FC: begin
                  tick = is_pwm & ~low_speed_mode;
               end
               `TCM_SEL_PIN: begin
                  tick = ev_fall & (mode == `TCM_MODE_TIMER);
               end
               default: begin
                  tick = 1'b0;
               end
            endcase
         end

         tcm_channel #(
            .CNT_W (CNT_W)
         ) u_channel (
            .pclk              (pclk),
            .presetn           (presetn),
            .tick              (tick),
            .run               (run),
            .mode              (mode),
            .ctrl_wr           (ctrl_wr),
            .wr_flop_level     (pwdata[`TCM_CTRL_FLOP]),
            .compare_value     (compare_value),
            .duty_wr           (duty_wr),
            .duty_wdata        (pwdata[CNT_W-1:0]),
            .count             (count),
            .pwm_duty_value    (pwm_duty_value),
            .out_flop          (out_flop),
            .channel_match_irq (channel_match_irq[gi])
         );

         // both pins drive the inverted flop, so each toggle or stopped control write preset moves them together
         assign divider_out_pin[gi] = ~out_flop;
         assign pwm_out_pin[gi]     = ~out_flop;

         // readback of this channel; the count word is for observation only
         always @* begin
            case (reg_off)
               `TCM_OFF_CTRL: begin
                  rd_word = {24'h000000, channel_control};
               end
               `TCM_OFF_CMP: begin
                  rd_word = {{(32-CNT_W){1'b0}}, compare_value};
               end
               `TCM_OFF_DUTY: begin
                  rd_word = {{(32-CNT_W){1'b0}}, pwm_duty_value};
               end
               default: begin
                  rd_word = {{(32-CNT_W){1'b0}}, count};
               end
            endcase
         end

         assign ch_rdata[gi] = rd_word;
      end
   endgenerate

   // read mux scales with the channel count; unmapped reads stay zero
   always @* begin
      next_prdata = 32'h00000000;
      if (cfg_hit) begin
         next_prdata = {30'h00000000, config_bits};
      end else begin
         for (ri = 0; ri < NUM_CH; ri = ri + 1) begin
            if (ch_hit[ri]) begin
               next_prdata = ch_rdata[ri];
            end
         end
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (setup_ph) begin
         prdata <= next_prdata;
      end
   end

endmodule
